// [hdl/srm_top.sv]
// Reset sequencer and strap decoder of the switch
`timescale 1ns/1ps
module srm_top #(
    parameter int RST_SEQ_CYCLES = srm_pkg::RST_SEQ_CYC,   // Reset procedure length
    parameter int NUM_PART       = srm_pkg::PART_W         // Partitions
) (
    input  wire logic                      sys_clk,
    input  wire logic                      srst,
    input  wire logic                      clk_en,
    input  wire logic                      merge_ports_8_9_n,
    input  wire logic                      merge_ports_12_13_n,
    input  wire logic                      global_reset_n,
    input  wire logic                      reset_halt,
    input  wire logic [3:0]                switch_mode_strap,
    input  wire logic [NUM_PART-1:0]       part_reset_n,
    input  wire logic                      halt_bit_clear,
    output logic                           core_reset,
    output logic                           smbus_enable,
    output logic                           halt_bit,
    output logic [NUM_PART-1:0]            part_reset,
    output logic                           port8_x8,
    output logic                           port12_x8,
    output logic [7:0]                     port8_lane_owner,
    output logic [7:0]                     port12_lane_owner,
    output logic                           mode_multi,
    output logic                           mode_eeprom_init,
    output logic                           port0_enable,
    output logic                           port2_enable,
    output logic                           mode_reserved,
    output logic [3:0]                     switch_mode_latched
);
    // Pin bundle layout: merge straps, halt, global reset, mode strap, partition resets
    localparam int PIN_W = 2 + 1 + 1 + srm_pkg::MODE_W + NUM_PART;

    // Synchroniser carrier
    srm_sync_if #(.W(PIN_W)) pin_if ();

    // All strap and reset pins into one bundle
    assign pin_if.raw = {part_reset_n, switch_mode_strap, global_reset_n,
                         reset_halt, merge_ports_12_13_n, merge_ports_8_9_n};

    // Pins pass two flops before use; partition resets idle high, global reset and straps idle low
    srm_sync #(
        .W       (PIN_W),
        .RST_VAL ({{NUM_PART{1'b1}}, srm_pkg::MODE_RST, 1'b0, 1'b0,
                   srm_pkg::MERGE_N_RST, srm_pkg::MERGE_N_RST})
    ) u_sync (
        .sys_clk (sys_clk),
        .srst    (srst),
        .clk_en  (clk_en),
        .pins    (pin_if.dst)
    );

    // Synchronised pin views
    logic                   s_m89_n;            // Merge 8/9, active low
    logic                   s_m1213_n;          // Merge 12/13, active low
    logic                   s_halt;             // Reset halt level
    logic                   s_grst_n;           // Global reset, active low
    logic [3:0]             s_mode;             // Switch mode strap
    logic [NUM_PART-1:0]    s_prst_n;           // Partition resets, active low

    assign {s_prst_n, s_mode, s_grst_n, s_halt, s_m1213_n, s_m89_n} = pin_if.sync;

    // Whole state of the block
    typedef struct packed {
        srm_pkg::srm_seq_type   seq;            // Sequencer state
        logic [srm_pkg::CNT_W-1:0] cnt;         // Procedure counter
        logic                   halt;           // Halt bit of control register
        logic                   m89_n;          // Latched merge 8/9
        logic                   m1213_n;        // Latched merge 12/13
        logic [3:0]             mode;           // Latched switch mode
        logic [NUM_PART-1:0]    prst;           // Partition reset outputs
    } srm_state_type;

    srm_state_type st_q;
    srm_state_type st_d;

    // Last count of the reset procedure, cut to counter width
    localparam int                        CNT_LAST_I = RST_SEQ_CYCLES - 1;              // Full-width last count
    localparam logic [srm_pkg::CNT_W-1:0] CNT_LAST   = CNT_LAST_I[srm_pkg::CNT_W-1:0];  // Counter-width copy

    // Decoded mode
    srm_pkg::srm_mode_type dec;

    // Mode decoder on the latched strap value
    always_comb begin
        dec = '0;
        case (st_q.mode)
            srm_pkg::MODE_SINGLE:    dec = '0;                                    // RULE_09
            srm_pkg::MODE_SINGLE_EE: dec.eeprom = 1'b1;                           // RULE_09
            srm_pkg::MODE_UP0:       dec.up_sel = 1'b1;                           // RULE_10
            srm_pkg::MODE_UP2: begin
                dec.up_sel   = 1'b1;                                              // RULE_10
                dec.up_port2 = 1'b1;
            end
            srm_pkg::MODE_UP0_EE: begin
                dec.up_sel = 1'b1;                                                // RULE_10
                dec.eeprom = 1'b1;
            end
            srm_pkg::MODE_UP2_EE: begin
                dec.up_sel   = 1'b1;                                              // RULE_10
                dec.up_port2 = 1'b1;
                dec.eeprom   = 1'b1;
            end
            srm_pkg::MODE_MULTI:     dec.multi = 1'b1;                            // RULE_11
            srm_pkg::MODE_MULTI_EE: begin
                dec.multi  = 1'b1;                                                // RULE_11
                dec.eeprom = 1'b1;
            end
            // Reserved values only flagged; board must not drive them
            default:                 dec.reserved = 1'b1;                         // RULE_12
        endcase
    end

    // Next state: sequencer, strap latch, halt bit, partition resets
    always_comb begin
        st_d = st_q;
        if (clk_en) begin
            case (st_q.seq)
                srm_pkg::SEQ_RESET: begin
                    // Hold everything in reset while global reset low
                    st_d.cnt  = '0;
                    st_d.halt = s_halt;                                           // RULE_07
                    st_d.prst = '1;
                    if (s_grst_n) begin
                        // Capture straps on release, kept until next reset
                        st_d.m89_n   = s_m89_n;                                   // RULE_15
                        st_d.m1213_n = s_m1213_n;                                 // RULE_15
                        st_d.mode    = s_mode;                                    // RULE_15
                        st_d.seq     = srm_pkg::SEQ_PROC;
                    end
                end
                srm_pkg::SEQ_PROC: begin
                    // Run the internal reset procedure
                    st_d.cnt = st_q.cnt + 1'b1;
                    if (st_q.cnt == CNT_LAST) begin
                        st_d.seq = st_q.halt ? srm_pkg::SEQ_HALT                  // RULE_07
                                             : srm_pkg::SEQ_RUN;
                    end
                end
                srm_pkg::SEQ_HALT: begin
                    // Stay halted until SMBus master clears the bit
                    if (halt_bit_clear) begin
                        st_d.halt = 1'b0;                                         // RULE_08
                        st_d.seq  = srm_pkg::SEQ_RUN;                             // RULE_08
                    end
                end
                srm_pkg::SEQ_RUN: begin
                    // Partition resets follow their pins
                    st_d.prst = ~s_prst_n;                                        // RULE_14
                end
                default: st_d.seq = srm_pkg::SEQ_RESET;
            endcase
            // Global reset overrides the next sequencer state, only while clk_en is high
            if (!s_grst_n) begin
                st_d.seq = srm_pkg::SEQ_RESET;                                    // RULE_06
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_q <= '{seq:     srm_pkg::SEQ_RESET,
                      cnt:     '0,
                      halt:    1'b0,
                      m89_n:   srm_pkg::MERGE_N_RST,
                      m1213_n: srm_pkg::MERGE_N_RST,
                      mode:    srm_pkg::MODE_RST,
                      prst:    '1};
        end else begin
            st_q <= st_d;
        end
    end

    // Core held in reset except while running
    assign core_reset   = (st_q.seq != srm_pkg::SEQ_RUN);                       // RULE_06
    // SMBus interfaces live once global reset has released
    assign smbus_enable = (st_q.seq != srm_pkg::SEQ_RESET);                     // RULE_07
    assign halt_bit     = st_q.halt;
    assign part_reset   = st_q.prst | {NUM_PART{core_reset}};                   // RULE_14

    // Merge configuration, low strap merges
    assign port8_x8  = ~st_q.m89_n;                                             // RULE_01 RULE_03 RULE_05
    assign port12_x8 = ~st_q.m1213_n;                                           // RULE_04 RULE_05

    // Lane ownership: bit set means lane belongs to the partner port
    assign port8_lane_owner  = port8_x8  ? 8'hF0 : 8'h00;                       // RULE_02
    assign port12_lane_owner = port12_x8 ? 8'hF0 : 8'h00;                       // RULE_04

    // Mode outputs
    assign mode_multi       = dec.multi;                                        // RULE_11
    assign mode_eeprom_init = dec.eeprom;                                       // RULE_09
    assign port0_enable     = ~(dec.up_sel &  dec.up_port2);                    // RULE_10
    assign port2_enable     = ~(dec.up_sel & ~dec.up_port2);                    // RULE_10
    assign mode_reserved    = dec.reserved;
    assign switch_mode_latched = st_q.mode;
endmodule : srm_top

// [hdl/srm_pkg.sv]
// Constants and types for the switch reset and mode strap block
// Notes on behaviour
// RULE_01: Low 8/9 strap merges ports 8, 9.
// RULE_02: Merged port 9 lanes become 4-7.
// RULE_03: High 8/9 strap keeps two x4 ports.
// RULE_04: 12/13 strap merges likewise, else x4.
// RULE_05: Merge straps active low, undriven means merged.
// RULE_06: Global reset resets all switch logic.
// RULE_07: Halt during reset holds reset, SMBus alive.
// RULE_08: Halt ends when SMBus master clears bit.
// RULE_09: Mode 0x0 single, 0x1 adds EEPROM init.
// RULE_10: Modes 0x8-0xB pick upstream port 0/2.
// RULE_11: Modes 0xC, 0xD multi-partition, second EEPROM.
// RULE_12: Board never drives reserved mode values.
// RULE_13: Board holds mode straps stable after reset.
// RULE_14: Partition reset input resets that partition only.
// RULE_15: Straps latched at reset release, held after.
package srm_pkg;

    // Strap field widths
    localparam int MODE_W  = 4;                 // Switch mode strap width
    localparam int PART_W  = 4;                 // Number of partitions
    localparam int LANE_W  = 8;                 // Lanes of a merged port
    localparam int HALF_W  = 4;                 // Lanes of an unmerged port

    // Switch mode encodings
    localparam logic [3:0] MODE_SINGLE       = 4'h0;
    localparam logic [3:0] MODE_SINGLE_EE    = 4'h1;
    localparam logic [3:0] MODE_UP0          = 4'h8;
    localparam logic [3:0] MODE_UP2          = 4'h9;
    localparam logic [3:0] MODE_UP0_EE       = 4'hA;
    localparam logic [3:0] MODE_UP2_EE       = 4'hB;
    localparam logic [3:0] MODE_MULTI        = 4'hC;
    localparam logic [3:0] MODE_MULTI_EE     = 4'hD;

    // Reset values of latched straps
    localparam logic       MERGE_N_RST       = 1'h0;   // Internal pull-down: merged
    localparam logic [3:0] MODE_RST          = 4'h0;

    // Reset sequencer timing
    localparam int RST_SEQ_NS = 1000;             // Internal reset procedure length
    localparam int CLK_NS     = 25;               // Clock period at 40 MHz
    localparam int RST_SEQ_CYC = (RST_SEQ_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W      = 8;                // Width of sequence counter

    // Reset sequencer states, one-hot
    typedef enum logic [3:0] {
        SEQ_RESET = 4'h1,                           // Global reset held
        SEQ_PROC  = 4'h2,                           // Running reset procedure
        SEQ_HALT  = 4'h4,                           // Halted in reset
        SEQ_RUN   = 4'h8                            // Normal operation
    } srm_seq_type;

    // Decoded mode fields
    typedef struct packed {
        logic multi;                                // Multi-partition
        logic eeprom;                               // Serial EEPROM init
        logic up_sel;                               // Upstream selection forced
        logic up_port2;                             // Upstream is port 2
        logic reserved;                             // Reserved value seen
    } srm_mode_type;

endpackage : srm_pkg

// [hdl/srm_sync_if.sv]
// Carrier between the top and its pin synchroniser
`timescale 1ns/1ps
interface srm_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;                              // Pins as they arrive
    logic [W-1:0] sync;                             // Pins after two flops
    modport src (output raw, input sync);
    modport dst (input raw, output sync);
endinterface : srm_sync_if

// [hdl/srm_sync.sv]
// Two-flop synchroniser for strap and reset pins
`timescale 1ns/1ps
module srm_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic  sys_clk,
    input  wire logic  srst,
    input  wire logic  clk_en,
    srm_sync_if.dst    pins
);
    // State of the synchroniser
    typedef struct packed {
        logic [W-1:0] meta;                         // First stage, read only by second
        logic [W-1:0] sync;                         // Second stage
    } srm_sync_state_type;

    srm_sync_state_type st_q;
    srm_sync_state_type st_d;

    // Next state: shift pins through two stages
    always_comb begin
        st_d = st_q;
        if (clk_en) begin
            st_d.meta = pins.raw;
            st_d.sync = st_q.meta;
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_q <= '{meta: RST_VAL, sync: RST_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign pins.sync = st_q.sync;
endmodule : srm_sync

// [dv/srm_top_monitor.sv]
// Port checker for the reset sequencer and strap decoder
`timescale 1ns/1ps
module srm_top_monitor #(
    parameter int RST_SEQ_CYCLES = 40,              // Reset procedure length
    parameter int NUM_PART       = 4                // Partitions
) (
    input wire logic                sys_clk,
    input wire logic                srst,
    input wire logic                clk_en,
    input wire logic                global_reset_n,
    input wire logic [NUM_PART-1:0] part_reset_n,
    input wire logic                halt_bit_clear,
    input wire logic                core_reset,
    input wire logic                smbus_enable,
    input wire logic                halt_bit,
    input wire logic [NUM_PART-1:0] part_reset,
    input wire logic                port8_x8,
    input wire logic                port12_x8,
    input wire logic [7:0]          port8_lane_owner,
    input wire logic [7:0]          port12_lane_owner,
    input wire logic                mode_multi,
    input wire logic                mode_eeprom_init,
    input wire logic                port0_enable,
    input wire logic                port2_enable,
    input wire logic [3:0]          switch_mode_latched
);
    // One clock domain, reset by srst
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    lanes_pair89_a: assert property (
        port8_lane_owner == (port8_x8 ? 8'hF0 : 8'h00)) else $error("lane map of pair 8/9 wrong");
    lanes_pair1213_a: assert property (
        port12_lane_owner == (port12_x8 ? 8'hF0 : 8'h00)) else $error("lane map of pair 12/13 wrong");
    strap_hold_a: assert property (
        smbus_enable && $past(smbus_enable) |-> $stable(switch_mode_latched) && $stable(port8_x8)
        && $stable(port12_x8)) else $error("latched straps moved out of reset");
    multi_decode_a: assert property (
        mode_multi == (switch_mode_latched inside {4'hC, 4'hD})) else $error("multi decode wrong");
    eeprom_decode_a: assert property (
        mode_eeprom_init == (switch_mode_latched inside {4'h1, 4'hA, 4'hB, 4'hD}))
        else $error("eeprom decode wrong");
    upstream_zero_a: assert property (
        switch_mode_latched inside {4'h8, 4'hA} |-> port0_enable && !port2_enable)
        else $error("port 0 upstream wrong");
    upstream_two_a: assert property (
        switch_mode_latched inside {4'h9, 4'hB} |-> port2_enable && !port0_enable)
        else $error("port 2 upstream wrong");
    reset_hold_a: assert property (
        (!global_reset_n && clk_en) [*3] |=> core_reset && !smbus_enable && (&part_reset))
        else $error("global reset not applied");
    halt_stay_a: assert property (
        halt_bit && smbus_enable && !halt_bit_clear |=> core_reset) else $error("left halt early");
    halt_exit_a: assert property (
        !core_reset |-> !halt_bit) else $error("running with halt bit set");
    part_hit_a: assert property (
        (!core_reset && clk_en && !part_reset_n[2]) [*3] |=> part_reset[2])
        else $error("partition reset ignored");
endmodule : srm_top_monitor

bind srm_top srm_top_monitor #(.RST_SEQ_CYCLES(RST_SEQ_CYCLES), .NUM_PART(NUM_PART)) i_srm_top_monitor (
    .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .global_reset_n(global_reset_n),
    .part_reset_n(part_reset_n), .halt_bit_clear(halt_bit_clear), .core_reset(core_reset),
    .smbus_enable(smbus_enable), .halt_bit(halt_bit), .part_reset(part_reset), .port8_x8(port8_x8),
    .port12_x8(port12_x8), .port8_lane_owner(port8_lane_owner), .port12_lane_owner(port12_lane_owner),
    .mode_multi(mode_multi), .mode_eeprom_init(mode_eeprom_init), .port0_enable(port0_enable),
    .port2_enable(port2_enable), .switch_mode_latched(switch_mode_latched));

// [dv/srm_board.sv]
// Board model: reset logic, strap resistors and bus master
`timescale 1ns/1ps
module srm_board (
    input  wire logic       sys_clk,
    input  wire logic       reset_req,                  // Hold global reset
    input  wire logic [3:0] mode_req,                   // Wanted switch mode
    input  wire logic [1:0] merge_drv,                  // Strap driven, else floating
    input  wire logic [1:0] merge_val,                  // Driven strap level
    input  wire logic       halt_req,                   // Ask for halt in reset
    input  wire logic [3:0] part_req,                   // Partition resets wanted
    input  wire logic       clear_req,                  // Master may clear halt
    input  wire logic       halt_bit,                   // Halt bit seen by master
    output logic            global_reset_n = 1'b0,
    output logic            merge_ports_8_9_n,
    output logic            merge_ports_12_13_n,
    output logic            reset_halt = 1'b0,
    output logic [3:0]      switch_mode_strap = 4'h0,
    output logic [3:0]      part_reset_n = 4'hF,
    output logic            halt_bit_clear = 1'b0
);
    // Floating merge straps fall to the internal pull-down
    assign merge_ports_8_9_n   = merge_drv[0] ? merge_val[0] : 1'b0;
    assign merge_ports_12_13_n = merge_drv[1] ? merge_val[1] : 1'b0;
    // Board moves its pins on the falling edge only
    always @(negedge sys_clk) begin
        global_reset_n <= !reset_req;
        reset_halt     <= halt_req;
        part_reset_n   <= ~part_req;
        // Mode changes only under reset, never to a reserved code
        if (reset_req && !(mode_req inside {[4'h2:4'h7], 4'hE, 4'hF})) begin
            switch_mode_strap <= mode_req;
        end
        // Master clears the halt bit with a one-cycle pulse
        halt_bit_clear <= clear_req && halt_bit && !halt_bit_clear;
    end
endmodule : srm_board

// [dv/tb_srm_top.sv]
// Testbench of the reset sequencer and strap decoder
`timescale 1ns/1ps
module tb_srm_top;
    localparam int SEQ = 3;                                     // Shortened reset procedure
    localparam logic [3:0] MODES [8] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
    logic       sys_clk = 1'b0, srst = 1'b1, reset_req = 1'b1, halt_req = 1'b0, clear_req = 1'b0;
    logic [3:0] mode_req = 4'h0, part_req = 4'h0, part_reset, switch_mode_latched, smode, prst_n;
    logic [1:0] merge_drv = 2'b00, merge_val = 2'b00;
    logic       clk_en = 1'b1;                                  // Clock enable of the design
    logic       m89_n, m1213_n, grst_n, rhalt, hclr, core_reset, smbus_enable, halt_bit;
    logic       port8_x8, port12_x8, mode_multi, mode_eeprom_init, port0_enable, port2_enable, mode_reserved;
    logic [7:0] port8_lane_owner, port12_lane_owner;
    int         errors = 0, total_checks = 0;

    // 40 MHz clock
    initial forever #12.5 sys_clk = ~sys_clk;

    srm_board i_srm_board (.sys_clk(sys_clk), .reset_req(reset_req), .mode_req(mode_req),
        .merge_drv(merge_drv), .merge_val(merge_val), .halt_req(halt_req), .part_req(part_req),
        .clear_req(clear_req), .halt_bit(halt_bit), .global_reset_n(grst_n), .merge_ports_8_9_n(m89_n),
        .merge_ports_12_13_n(m1213_n), .reset_halt(rhalt), .switch_mode_strap(smode),
        .part_reset_n(prst_n), .halt_bit_clear(hclr));
    srm_top #(.RST_SEQ_CYCLES(SEQ)) i_srm_top (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
        .merge_ports_8_9_n(m89_n), .merge_ports_12_13_n(m1213_n), .global_reset_n(grst_n),
        .reset_halt(rhalt), .switch_mode_strap(smode), .part_reset_n(prst_n), .halt_bit_clear(hclr),
        .core_reset(core_reset), .smbus_enable(smbus_enable), .halt_bit(halt_bit), .part_reset(part_reset),
        .port8_x8(port8_x8), .port12_x8(port12_x8), .port8_lane_owner(port8_lane_owner),
        .port12_lane_owner(port12_lane_owner), .mode_multi(mode_multi), .mode_eeprom_init(mode_eeprom_init),
        .port0_enable(port0_enable), .port2_enable(port2_enable), .mode_reserved(mode_reserved),
        .switch_mode_latched(switch_mode_latched));

    // Compare one value and count it
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // Print counts and verdict, then stop
    task automatic finish_test();
        $display("Checks %0d, errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    // Global reset with given straps, then release and wait
    task automatic boot(input logic [3:0] mode, input logic [1:0] drv, input logic [1:0] val, input logic halt);
        @(negedge sys_clk);
        reset_req <= 1'b1;
        mode_req  <= mode;
        merge_drv <= drv;
        merge_val <= val;
        halt_req  <= halt;
        repeat (6) @(negedge sys_clk);
        check(core_reset, 1'b1);
        check(smbus_enable, 1'b0);
        check(part_reset, 4'hF);
        reset_req <= 1'b0;
        if (halt) begin
            repeat (15) @(negedge sys_clk);
        end else begin
            for (int i = 0; i < 30 && core_reset !== 1'b0; i++) @(negedge sys_clk);
        end
    endtask : boot

    // Main sequence
    initial begin
        logic [3:0] m;
        logic       s89, s12;
        repeat (5) @(negedge sys_clk);
        srst <= 1'b0;
        // Every valid mode, with merge straps driven and floating
        for (int i = 0; i < 8; i++) begin
            m = MODES[i];
            boot(m, 2'(i), 2'(i >> 1), 1'b0);
            s89 = (i % 2 == 1) && ((i >> 1) % 2 == 1);
            s12 = ((i >> 1) % 2 == 1) && ((i >> 2) % 2 == 1);
            check(core_reset, 1'b0);
            check(switch_mode_latched, m);
            check(mode_multi, m inside {4'hC, 4'hD});
            check(mode_eeprom_init, m inside {4'h1, 4'hA, 4'hB, 4'hD});
            check(port0_enable, !(m inside {4'h9, 4'hB}));
            check(port2_enable, !(m inside {4'h8, 4'hA}));
            check(mode_reserved, 1'b0);
            check(port8_x8, !s89);
            check(port8_lane_owner, s89 ? 8'h00 : 8'hF0);
            check(port12_x8, !s12);
            check(port12_lane_owner, s12 ? 8'h00 : 8'hF0);
        end
        // Halt in reset until the master clears the bit
        boot(4'h1, 2'b11, 2'b11, 1'b1);
        check({core_reset, smbus_enable, halt_bit}, 3'b111);
        clear_req <= 1'b1;
        repeat (4) @(negedge sys_clk);
        check({core_reset, halt_bit}, 2'b00);
        clear_req <= 1'b0;
        // One partition reset leaves the others running
        part_req <= 4'h4;
        repeat (5) @(negedge sys_clk);
        check({core_reset, part_reset}, 5'h04);
        part_req <= 4'h0;
        repeat (5) @(negedge sys_clk);
        check(part_reset, 4'h0);
        // Clock enable low freezes partition resets until raised
        clk_en   <= 1'b0;
        part_req <= 4'h1;
        repeat (5) @(negedge sys_clk);
        check(part_reset, 4'h0);
        clk_en <= 1'b1;
        repeat (5) @(negedge sys_clk);
        check(part_reset, 4'h1);
        finish_test();
    end

    // Watchdog: run needs well under 500 cycles
    initial begin
        #50000;
        errors++;
        finish_test();
    end
endmodule : tb_srm_top
